// >>> sosc_pkg.sv
`default_nettype none

package sosc_pkg;

    // clock and output-carrier timing
    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned PWM_FREQ_HZ    = 300;
    // longest time per carrier period, so rounded down
    localparam int unsigned PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
    localparam int unsigned PWM_CNT_W      = 17;

    // widths
    localparam int unsigned DAC_W   = 16;
    localparam int unsigned CLAMP_W = 8;
    localparam int unsigned DUTY_W  = 12;
    localparam int unsigned RATE_W  = 3;
    localparam int unsigned MODE_W  = 3;

    // output mode field codes
    localparam logic [2:0] MODE_VOLT     = 3'h0;
    localparam logic [1:0] MODE_LOOP_TOP = 2'h1;  // pattern 01x, low bit ignored
    localparam logic [2:0] MODE_PDM      = 3'h4;
    localparam logic [2:0] MODE_PWM      = 3'h5;

    // clamp levels: field / 2^9 of full scale, i.e. field shifted into a 16-bit word
    localparam int unsigned CLAMP_SHIFT = 7;
    localparam logic [DAC_W:0] FULL_CODE = 17'h10000;

    // reset values
    localparam logic [DAC_W-1:0] DAC_RESET = 16'h0000;

    // full-scale range codes
    typedef enum logic [1:0] {
        SOSC_FS_5V0   = 2'b00,
        SOSC_FS_3V3   = 2'b01,
        SOSC_FS_1V2   = 2'b10,
        SOSC_FS_RATIO = 2'b11
    } sosc_fs_t;

    // resolved output stage configuration
    typedef enum logic [2:0] {
        SOSC_ST_OFF  = 3'b000,
        SOSC_ST_VOLT = 3'b001,
        SOSC_ST_LOOP = 3'b010,
        SOSC_ST_PDM  = 3'b011,
        SOSC_ST_PWM  = 3'b100
    } sosc_stage_t;

    // configuration bits written by software
    typedef struct packed {
        logic [MODE_W-1:0] out_mode;
        sosc_fs_t          converter_fullscale;
        logic              raw_primary;
        logic              dac_blank;
        logic [RATE_W-1:0] density_rate_setting;
    } sosc_cfg_t;

    // clamp fields
    typedef struct packed {
        logic [CLAMP_W-1:0] high;
        logic [CLAMP_W-1:0] low;
    } sosc_clamp_t;

    // analog stage controls
    typedef struct packed {
        sosc_stage_t      stage;
        sosc_fs_t         range;
        logic             buf_en;
        logic             loop_en;
        logic             blank;
        logic [DAC_W-1:0] code;
    } sosc_ana_t;

endpackage : sosc_pkg

`default_nettype wire

// >>> sosc_skid.sv
`timescale 1ns/1ps
`default_nettype none

module sosc_skid #(
    parameter int unsigned W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);

    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic              rd;
        logic              wr;
        logic [1:0]        cnt;
        logic              rdy;
    } sosc_skid_st_t;

    sosc_skid_st_t s_q;
    sosc_skid_st_t s_d;
    logic          push;
    logic          pop;

    // ready from a register so the source never sees a combinational path
    assign in_ready_o  = s_q.rdy;
    assign out_valid_o = (s_q.cnt != 2'h0);
    assign out_data_o  = s_q.mem[s_q.rd];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // two-entry ring, full only when both slots hold a word
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_data_i;
            s_d.wr          = ~s_q.wr;
        end
        if (pop) begin
            s_d.rd = ~s_q.rd;
        end
        s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
        s_d.rdy = (s_d.cnt != 2'h2);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q     <= '0;
            s_q.rdy <= 1'b1;  // empty after reset, so ready at once
        end else begin
            s_q <= s_d;
        end
    end

endmodule // sosc_skid

`default_nettype wire

// >>> sosc_top.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - mode 000 selects buffered voltage output
// - mode 01x with range zero: loop
// - mode 100 drives first-order density stream
// - density rate follows programmed rate setting
// - DAC word unsigned, fraction of range
// - range code: 5V, 3.3V, 1.2V, ratiometric
// - raw bit clear: calibration results load word
// - low clamp equals field over 512
// - high clamp equals one minus field/512
// - output held between low and high clamps
// - raw bit set: host writes word
// - output mode independent of front-end settings
// - loop current is word times 24mA
// - 0-10V uses voltage path, range zero
// - mode 101: 300Hz pulse width, 12-bit duty
module sosc_top
    import sosc_pkg::*;
#(
    parameter int unsigned PWM_PERIOD = PWM_PERIOD_CYC
) (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire sosc_pkg::sosc_cfg_t       cfg_i,
    input  wire sosc_pkg::sosc_clamp_t     clamp_i,
    input  wire logic                      cal_valid_i,
    output logic                           cal_ready_o,
    input  wire logic [sosc_pkg::DAC_W-1:0] cal_data_i,
    input  wire logic                      host_wr_i,
    input  wire logic [sosc_pkg::DAC_W-1:0] host_data_i,
    output sosc_pkg::sosc_ana_t            ana_o,
    output logic [sosc_pkg::DAC_W-1:0]     dac_word_o,
    output logic                           out_pin_o,
    output logic                           out_pin_oe_o
);

    import sosc_pkg::*;

    localparam logic [PWM_CNT_W-1:0] PWM_LAST = PWM_CNT_W'(PWM_PERIOD - 1);

    typedef struct packed {
        logic [DAC_W-1:0]     word;
        sosc_ana_t            ana;
        logic [DAC_W-1:0]     acc;
        logic [7:0]           rate_cnt;
        logic [PWM_CNT_W-1:0] pwm_cnt;
        logic [PWM_CNT_W-1:0] pwm_thr;
        logic                 pin;
        logic                 pin_oe;
    } sosc_st_t;

    sosc_st_t         s_q;
    sosc_st_t         s_d;
    logic             buf_valid;
    logic             buf_ready;
    logic [DAC_W-1:0] buf_data;
    sosc_stage_t      stage;
    logic [DAC_W:0]   lo_lvl;
    logic [DAC_W:0]   hi_lvl;
    logic [DAC_W-1:0] clamped;
    logic [DAC_W:0]   acc_sum;
    logic             rate_tick;
    logic [DUTY_W+PWM_CNT_W-1:0] pwm_prod;

    // resolve the mode field and range into one stage choice
    function automatic sosc_stage_t stage_of(input logic [MODE_W-1:0] m,
                                             input sosc_fs_t fs);
        sosc_stage_t r;
        r = SOSC_ST_OFF;
        if (m == MODE_VOLT) begin
            r = SOSC_ST_VOLT;
        end else if (m[2:1] == MODE_LOOP_TOP) begin
            // loop only on the 5V absolute range; other ranges leave the stage off
            r = (fs == SOSC_FS_5V0) ? SOSC_ST_LOOP : SOSC_ST_OFF;
        end else if (m == MODE_PDM) begin
            r = SOSC_ST_PDM;
        end else if (m == MODE_PWM) begin
            r = SOSC_ST_PWM;
        end
        return r;
    endfunction

    // calibration results wait here; a blanking host stall loses no word
    sosc_skid #(
        .W (DAC_W)
    ) u_cal_buf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (cal_valid_i),
        .in_ready_o  (cal_ready_o),
        .in_data_i   (cal_data_i),
        .out_valid_o (buf_valid),
        .out_ready_i (buf_ready),
        .out_data_o  (buf_data)
    );

    // only the output-stage fields feed the stage; front-end settings never enter
    assign stage = stage_of(cfg_i.out_mode, cfg_i.converter_fullscale);

    // while raw, drained words are discarded; while blanked and not raw, the buffer holds them
    assign buf_ready = cfg_i.raw_primary || !cfg_i.dac_blank;

    // clamp window in 17 bits so a zero high field reaches full scale
    assign lo_lvl = {1'b0, clamp_i.low, 8'h00} >> 1;
    assign hi_lvl = FULL_CODE - ({1'b0, clamp_i.high, 8'h00} >> 1);

    // low clamp wins if the two levels cross
    always_comb begin
        clamped = s_q.word;
        if ({1'b0, s_q.word} >= hi_lvl) begin
            clamped = DAC_W'(hi_lvl - 17'h00001);
        end
        if ({1'b0, s_q.word} < lo_lvl) begin
            clamped = lo_lvl[DAC_W-1:0];
        end
    end

    // modulator step rate: one step every 2^setting clocks
    assign rate_tick = (s_q.rate_cnt == ((8'h01 << cfg_i.density_rate_setting) - 8'h01));
    assign acc_sum   = {1'b0, s_q.acc} + {1'b0, s_q.ana.code};

    // duty threshold, scaled from 4096 steps onto the carrier period
    assign pwm_prod = s_q.ana.code[DAC_W-1:DAC_W-DUTY_W] * PWM_CNT_W'(PWM_PERIOD);

    always_comb begin
        s_d = s_q;

        // word source: calibration stream or host write
        if (cfg_i.raw_primary) begin
            if (host_wr_i) begin
                s_d.word = host_data_i;
            end
        end else if (buf_valid && buf_ready) begin
            s_d.word = buf_data;
        end

        // analog controls; the code freezes while blanked to hide update glitches
        s_d.ana.stage   = stage;
        s_d.ana.range   = cfg_i.converter_fullscale;
        s_d.ana.buf_en  = (stage == SOSC_ST_VOLT);
        s_d.ana.loop_en = (stage == SOSC_ST_LOOP);
        s_d.ana.blank   = cfg_i.dac_blank;
        if (!cfg_i.dac_blank) begin
            s_d.ana.code = clamped;
        end

        // first-order modulator, carry out is the stream bit
        s_d.rate_cnt = rate_tick ? 8'h00 : s_q.rate_cnt + 8'h01;
        if (stage == SOSC_ST_PDM) begin
            if (rate_tick) begin
                s_d.acc = acc_sum[DAC_W-1:0];
                s_d.pin = acc_sum[DAC_W];
            end
        end else begin
            s_d.acc = '0;
        end

        // fixed 300Hz carrier; threshold taken at period start to avoid runt pulses
        if (s_q.pwm_cnt == PWM_LAST) begin
            s_d.pwm_cnt = '0;
            s_d.pwm_thr = pwm_prod[DUTY_W+PWM_CNT_W-1:DUTY_W];
        end else begin
            s_d.pwm_cnt = s_q.pwm_cnt + 17'h00001;
        end
        if (stage == SOSC_ST_PWM) begin
            s_d.pin = (s_q.pwm_cnt < s_q.pwm_thr);
        end else if (stage != SOSC_ST_PDM) begin
            s_d.pin = 1'b0;
        end

        // digital pin drive only in the two bit-stream modes
        s_d.pin_oe = (stage == SOSC_ST_PDM) || (stage == SOSC_ST_PWM);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q           <= '0;
            s_q.word      <= DAC_RESET;
            s_q.ana.code  <= DAC_RESET;
            s_q.ana.stage <= SOSC_ST_OFF;
            s_q.ana.range <= SOSC_FS_5V0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ana_o        = s_q.ana;
    assign dac_word_o   = s_q.word;
    assign out_pin_o    = s_q.pin;
    assign out_pin_oe_o = s_q.pin_oe;

endmodule // sosc_top

`default_nettype wire

// >>> sosc_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sosc_top_chk
    import sosc_pkg::*;
#(
    parameter int unsigned PWM_PERIOD = PWM_PERIOD_CYC
) (
    input wire logic                        clk_i,
    input wire logic                        rst_i,
    input wire sosc_pkg::sosc_cfg_t         cfg_i,
    input wire sosc_pkg::sosc_clamp_t       clamp_i,
    input wire logic                        host_wr_i,
    input wire logic [sosc_pkg::DAC_W-1:0]  host_data_i,
    input wire sosc_pkg::sosc_ana_t         ana_o,
    input wire logic [sosc_pkg::DAC_W-1:0]  dac_word_o,
    input wire logic                        out_pin_o,
    input wire logic                        out_pin_oe_o
);
    import sosc_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // independent clamp model; low bound wins when the two cross
    function automatic logic [15:0] clamp_f(input logic [15:0] w, input sosc_clamp_t c);
        logic [16:0] hi;
        hi = FULL_CODE - {2'h0, c.high, 7'h00};
        clamp_f = ({1'b0, w} >= hi) ? hi[15:0] - 16'h0001 : w;
        if (w < {1'b0, c.low, 7'h00}) clamp_f = {1'b0, c.low, 7'h00};
    endfunction

    volt_stage_a: assert property (
        cfg_i.out_mode == MODE_VOLT |=> ana_o.stage == SOSC_ST_VOLT && ana_o.buf_en)
        else $error("voltage stage not selected");
    loop_stage_a: assert property (
        cfg_i.out_mode[2:1] == MODE_LOOP_TOP && cfg_i.converter_fullscale == SOSC_FS_5V0
        |=> ana_o.stage == SOSC_ST_LOOP && ana_o.loop_en) else $error("loop stage not selected");
    loop_off_a: assert property (
        cfg_i.out_mode[2:1] == MODE_LOOP_TOP && cfg_i.converter_fullscale != SOSC_FS_5V0
        |=> ana_o.stage == SOSC_ST_OFF) else $error("loop entered with nonzero range");
    pdm_stage_a: assert property (
        cfg_i.out_mode == MODE_PDM |=> ana_o.stage == SOSC_ST_PDM) else $error("pdm stage");
    pwm_stage_a: assert property (
        cfg_i.out_mode == MODE_PWM |=> ana_o.stage == SOSC_ST_PWM) else $error("pwm stage");
    host_write_a: assert property (
        host_wr_i && cfg_i.raw_primary |=> dac_word_o == $past(host_data_i))
        else $error("host word not stored");
    raw_hold_a: assert property (
        cfg_i.raw_primary [*3] ##0 !host_wr_i |=> $stable(dac_word_o))
        else $error("word changed in raw mode");
    clamp_code_a: assert property (
        !cfg_i.dac_blank |=> ana_o.code == clamp_f($past(dac_word_o), $past(clamp_i)))
        else $error("clamped code wrong");
    blank_hold_a: assert property (
        cfg_i.dac_blank |=> $stable(ana_o.code) && ana_o.blank) else $error("blank not held");
    volt_quiet_a: assert property (
        (ana_o.stage == SOSC_ST_VOLT) [*3] |-> !out_pin_oe_o && !out_pin_o)
        else $error("pin driven in voltage mode");
endmodule // sosc_top_chk

bind sosc_top sosc_top_chk #(.PWM_PERIOD(PWM_PERIOD)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg_i), .clamp_i(clamp_i), .host_wr_i(host_wr_i),
    .host_data_i(host_data_i), .ana_o(ana_o), .dac_word_o(dac_word_o), .out_pin_o(out_pin_o),
    .out_pin_oe_o(out_pin_oe_o));
`default_nettype wire

// >>> sosc_rc_model.sv
`timescale 1ns/1ps
`default_nettype none
module sosc_rc_model (
    input  wire logic  clk_i,
    input  wire logic  clr_i,
    input  wire logic  pin_i,
    input  wire logic  oe_i,
    output logic [15:0] high_o,
    output logic [15:0] rise_o
);
    logic lvl;
    logic last_q;
    // load resistor pulls the released pin low
    assign lvl = oe_i & pin_i;
    // filter stand-in: high time gives the average, rises give the rate
    always_ff @(posedge clk_i) begin
        last_q <= lvl;
        if (clr_i) begin
            high_o <= 16'h0000;
            rise_o <= 16'h0000;
        end else begin
            high_o <= high_o + {15'h0000, lvl};
            rise_o <= rise_o + {15'h0000, lvl & ~last_q};
        end
    end
endmodule // sosc_rc_model
`default_nettype wire

// >>> test_sosc_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_sosc_top;
    import sosc_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    sosc_cfg_t   cfg = '0;
    sosc_clamp_t clp = '0;
    logic        cal_v = 1'b0;
    logic        cal_rdy;
    logic [15:0] cal_d = 16'h0000;
    logic        hwr = 1'b0;
    logic [15:0] hd = 16'h0000;
    sosc_ana_t   ana;
    logic [15:0] word;
    logic        pin;
    logic        oe;
    logic        clr = 1'b1;
    logic [15:0] highs;
    logic [15:0] rises;
    int          n_mismatch = 0;
    int          comparisons = 0;

    // 20 MHz device clock
    always #25 clk_i = ~clk_i;

    sosc_top #(.PWM_PERIOD(4096)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg),
        .clamp_i(clp), .cal_valid_i(cal_v), .cal_ready_o(cal_rdy), .cal_data_i(cal_d),
        .host_wr_i(hwr), .host_data_i(hd), .ana_o(ana), .dac_word_o(word), .out_pin_o(pin),
        .out_pin_oe_o(oe));
    sosc_rc_model u_load (.clk_i(clk_i), .clr_i(clr), .pin_i(pin), .oe_i(oe),
        .high_o(highs), .rise_o(rises));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // one-cycle write strobe, then two quiet cycles
    task automatic strobe(input logic [15:0] w);
        hwr = 1'b1;
        hd = w;
        tick(1);
        hwr = 1'b0;
        tick(2);
    endtask
    // blank around the write so no update glitch reaches the output
    task automatic host(input logic [15:0] w);
        cfg.dac_blank = 1'b1;
        tick(1);
        strobe(w);
        cfg.dac_blank = 1'b0;
        tick(2);
    endtask
    task automatic report_and_stop;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic t_modes;
        sosc_stage_t e;
        for (int i = 0; i < 32; i++) begin
            cfg.out_mode = i[4:2];
            cfg.converter_fullscale = sosc_fs_t'(i[1:0]);
            tick(3);
            e = (i[4:2] == MODE_VOLT) ? SOSC_ST_VOLT : (i[4:3] == MODE_LOOP_TOP) ?
                ((i[1:0] == 0) ? SOSC_ST_LOOP : SOSC_ST_OFF) : (i[4:2] == MODE_PDM) ?
                SOSC_ST_PDM : (i[4:2] == MODE_PWM) ? SOSC_ST_PWM : SOSC_ST_OFF;
            check("stage", 16'(ana.stage), 16'(e));
            check("range", 16'(ana.range), 16'(i[1:0]));
            check("oe", 16'(oe), 16'(e == SOSC_ST_PDM || e == SOSC_ST_PWM));
        end
        cfg = '0;
    endtask

    task automatic t_host;
        logic [15:0] w[5] = '{16'h1234, 16'h0100, 16'hFFFF, 16'hF800, 16'h0800};
        logic [15:0] e[5] = '{16'h1234, 16'h0800, 16'hF7FF, 16'hF7FF, 16'h0800};
        cfg.raw_primary = 1'b1;
        clp = '{high: 8'h10, low: 8'h10};
        foreach (w[i]) begin
            host(w[i]);
            check("host word", word, w[i]);
            check("clamped", ana.code, e[i]);
        end
        // blanked update must not reach the code until the blank drops
        cfg.dac_blank = 1'b1;
        tick(1);
        strobe(16'h3000);
        check("blanked", ana.code, 16'h0800);
        check("blank flag", 16'(ana.blank), 16'h0001);
        cfg.dac_blank = 1'b0;
        tick(2);
        check("unblanked", ana.code, 16'h3000);
        clp = '0;
    endtask

    task automatic t_cal;
        int n;
        logic ok;
        cfg.raw_primary = 1'b0;
        cal_v = 1'b1;
        cal_d = 16'hA001;
        tick(1);
        cal_d = 16'hA002;
        tick(1);
        cal_v = 1'b0;
        check("cal first", word, 16'hA001);
        tick(1);
        check("cal second", word, 16'hA002);
        host(16'h5555);
        check("host ignored", word, 16'hA002);
        // stalled drain: only two words fit
        cfg.dac_blank = 1'b1;
        n = 0;
        cal_v = 1'b1;
        cal_d = 16'hC000;
        repeat (4) begin
            ok = cal_rdy;
            tick(1);
            if (ok) begin
                n++;
                cal_d = 16'hC000 + 16'(n);
            end
        end
        cal_v = 1'b0;
        check("accepted", 16'(n), 16'h0002);
        check("held", word, 16'hA002);
        cfg.dac_blank = 1'b0;
        tick(5);
        check("drained", word, 16'hC001);
        check("ready", 16'(cal_rdy), 16'h0001);
    endtask

    task automatic t_out;
        cfg.raw_primary = 1'b1;
        host(16'h4000);
        cfg.out_mode = MODE_PDM;
        // every rate setting; settle past the slowest step so the window is periodic
        for (int s = 0; s < 8; s++) begin
            cfg.density_rate_setting = 3'(s);
            tick(256);
            clr = 1'b0;
            tick(512);
            check("pdm duty", highs, 16'h0080);
            check("pdm rate", rises, 16'h0080 >> s);
            clr = 1'b1;
        end
        host(16'h8000);
        cfg.out_mode = MODE_PWM;
        tick(8200);
        clr = 1'b0;
        tick(4096);
        check("pwm duty", highs, 16'h0800);
    endtask

    // watchdog against a hang
    initial begin
        repeat (40000) @(posedge clk_i);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        tick(8);
        check("reset word", word, 16'h0000);
        check("reset stage", 16'(ana.stage), 16'(SOSC_ST_OFF));
        rst_i = 1'b0;
        tick(1);
        check("ready", 16'(cal_rdy), 16'h0001);
        t_modes();
        t_host();
        t_cal();
        t_out();
        report_and_stop();
    end
endmodule // test_sosc_top
`default_nettype wire
